// *** hw/cascade_defines.vh ***
`ifndef CASCADE_DEFINES_VH
`define CASCADE_DEFINES_VH
// register byte addresses, compared whole against the bus address
`define MSP_IDX_EXP      16'hf021
`define MSP_IDX_LEG      16'h0021
`define SID_IDX_EXP      16'hf0a1
`define SID_IDX_LEG      16'h00a1
`define CFG_IDX          16'hf0c0
`define ACC_IDX          16'hf0c1
// field positions
`define INTERNAL_SLAVE   3'h2
`define CFG_CASOUT_BIT   7
`define ACC_GO_BIT       3
// legal slave-present bits: 7,6,5,2,1
`define MSP_LEGAL_MASK   8'he6
// reset values
`define MSP_RST          8'h04
`define SID_RST          8'h02
`define CFG_RST          8'h00
`endif

// *** hw/interrupt_cascade_config.v ***
`timescale 1ns/1ns
// Operation
// - internal slave fixed on request input 2
// - external slaves only on inputs 7,6,5,1
// - slave-present bit n marks input n
// - master register at two addresses, read/write
// - slave identity at two addresses, bits 2:0
// - slave compares select code with identity
// - master drives addressed identity on cascade lines
// - config bit 7 routes select onto upper address
`include "cascade_defines.vh"
module interrupt_cascade_config
#(
    parameter AW = 16
)
(
    input  wire          mclk,
    input  wire          rst,
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [AW-1:0] wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    output reg  [2:0]    cascade_select_lines,
    output reg           cascade_active,
    output reg  [2:0]    upper_address_outputs,
    output reg           upper_address_oe,
    output reg           internal_slave_addressed
);
    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    reg  [7:0]  cascade_init_word_m_r;   // master slave-present register
    reg  [7:0]  cascade_init_word_s_r;   // internal slave identity register
    reg  [7:0]  interrupt_config_reg_r;  // bit 7 enables cascade on address
    reg  [2:0]  access_id_r;             // requested slave input number

    // bus decode
    wire        req;                     // new request, not yet answered
    wire        wr;                      // write strobe for byte lane 0
    wire        msp_sel;                 // master slave-present register hit
    wire        sid_sel;                 // slave identity register hit
    wire        cfg_sel;                 // configuration register hit
    wire        acc_sel;                 // access control register hit

    // cascade path
    wire        match;                   // requested input has a slave
    wire        casout_en;               // copy select onto address pins
    wire [2:0]  select_code;             // code for the select lines
    wire        go_present;              // start bit with slave present
    reg  [31:0] rdata;                   // read mux result

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // address compare used for each register
    function hit;
        input [AW-1:0] a;
        input [15:0]   b;
        begin
            hit = (a == b[AW-1:0]);
        end
    endfunction

    // a cascade word answers at its expanded and its legacy address
    function dual_hit;
        input [AW-1:0] a;
        input [15:0]   exp_addr;
        input [15:0]   leg_addr;
        begin
            // both decodes lead to the same flops, so no aliasing hazard
            dual_hit = hit(a, exp_addr) || hit(a, leg_addr);
        end
    endfunction

    // select code: identity while an access runs on a present slave, zero otherwise
    function [2:0] select_of;
        input       active;
        input       present;
        input [2:0] id;
        begin
            if (active && present)
                select_of = id;
            else
                select_of = 3'h0;
        end
    endfunction

    // value stored by a write to the master register
    function [7:0] msp_store;
        input [7:0] d;
        begin
            // illegal inputs dropped so a bad write cannot fake a slave;
            // input 2 always holds the internal slave
            msp_store = (d & `MSP_LEGAL_MASK) | (8'h01 << `INTERNAL_SLAVE);
        end
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------

    // bus request only while ack is low: single ack per cycle
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // only byte lane 0 carries the 8-bit registers
    assign wr  = req && wb_we_i && wb_sel_i[0];

    // register selects
    assign msp_sel = dual_hit(wb_adr_i, `MSP_IDX_EXP, `MSP_IDX_LEG);
    assign sid_sel = dual_hit(wb_adr_i, `SID_IDX_EXP, `SID_IDX_LEG);
    assign cfg_sel = hit(wb_adr_i, `CFG_IDX);
    assign acc_sel = hit(wb_adr_i, `ACC_IDX);

    // ------------------------------------------------------------------
    // cascade decode
    // ------------------------------------------------------------------

    // requested input is a slave only if its present bit is set
    assign match       = cascade_init_word_m_r[access_id_r];
    // cascade copy onto the upper address pins
    assign casout_en   = interrupt_config_reg_r[`CFG_CASOUT_BIT];
    // identity of the addressed slave, zero when idle
    assign select_code = select_of(cascade_active, match, access_id_r);
    // start check uses the incoming input number, not the stored one
    assign go_present  = wb_dat_i[`ACC_GO_BIT] && cascade_init_word_m_r[wb_dat_i[2:0]];

    // ------------------------------------------------------------------
    // read mux; unmapped reads return zero
    // ------------------------------------------------------------------
    always @*
    begin
        rdata = 32'h0000_0000;
        if (msp_sel)
            rdata[7:0] = cascade_init_word_m_r;
        else if (sid_sel)
            rdata[7:0] = cascade_init_word_s_r;
        else if (cfg_sel)
            rdata[7:0] = interrupt_config_reg_r;
        else if (acc_sel)
            // status read: busy flag above the input number
            rdata[7:0] = {4'h0, cascade_active, access_id_r};
    end

    // ------------------------------------------------------------------
    // register writes and one-cycle ack
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            // cascade words start as a working single-slave setup
            cascade_init_word_m_r  <= `MSP_RST;
            cascade_init_word_s_r  <= `SID_RST;
            interrupt_config_reg_r <= `CFG_RST;
            access_id_r            <= 3'h0;
            wb_ack_o               <= 1'b0;
            wb_dat_o               <= 32'h0000_0000;
        end
        else
        begin
            // ack follows a taken request by exactly one edge
            wb_ack_o <= req;
            // data stands only beside ack, zero otherwise
            wb_dat_o <= req ? rdata : 32'h0000_0000;
            if (wr && msp_sel)
                // internal slave bit forced; only legal inputs store
                cascade_init_word_m_r <= msp_store(wb_dat_i[7:0]);
            if (wr && sid_sel)
                // upper bits have no meaning, kept at zero
                cascade_init_word_s_r <= {5'h00, wb_dat_i[2:0]};
            if (wr && cfg_sel)
                interrupt_config_reg_r <= wb_dat_i[7:0];
            if (wr && acc_sel)
                access_id_r <= wb_dat_i[2:0];
        end
    end

    // ------------------------------------------------------------------
    // slave access: drive identity while go bit set and slave present
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (rst)
        begin
            cascade_select_lines  <= 3'h0;
            cascade_active        <= 1'b0;
            upper_address_outputs <= 3'h0;
            upper_address_oe      <= 1'b0;
        end
        else
        begin
            // a start on an empty input is refused: no slave to address
            if (wr && acc_sel)
                cascade_active <= go_present;
            // lines idle at zero outside an access
            cascade_select_lines <= select_code;
            // pins only driven while an access runs and the copy is enabled
            upper_address_oe <= cascade_active && casout_en;
            // copy lags nothing: same flop stage as the select lines
            if (casout_en)
                upper_address_outputs <= select_code;
            else
                upper_address_outputs <= 3'h0;
        end
    end

    // ------------------------------------------------------------------
    // internal slave decides whether it is addressed
    // ------------------------------------------------------------------
    // fed from the registered select lines, so the flag trails them by
    // one edge; external slaves see the same timing on the pins
    slave_id_match u_match
    (
        .mclk         (mclk),
        .rst          (rst),
        .select_code  (cascade_select_lines),
        .select_valid (cascade_active),
        .identity     (cascade_init_word_s_r[2:0]),
        .addressed_r  (internal_slave_addressed)
    );
endmodule

// *** hw/slave_id_match.v ***
`timescale 1ns/1ns
// compares cascade select code with a programmed identity
module slave_id_match
(
    input  wire       mclk,
    input  wire       rst,
    input  wire [2:0] select_code,
    input  wire       select_valid,
    input  wire [2:0] identity,
    output reg        addressed_r
);
    // registered so the consumer sees a clean flag
    always @(posedge mclk)
    begin
        if (rst)
            addressed_r <= 1'b0;
        else
            addressed_r <= select_valid && (select_code == identity);
    end
endmodule

// *** test/cascade_checker.sv ***
`timescale 1ns/1ns
module cascade_checker
(
    input wire        mclk,
    input wire        rst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_ack_o,
    input wire [31:0] wb_dat_o,
    input wire [2:0]  cascade_select_lines,
    input wire        cascade_active,
    input wire [2:0]  upper_address_outputs,
    input wire        upper_address_oe,
    input wire        internal_slave_addressed
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 0) else $error("dat");
    a_sel_legal: assert property (cascade_select_lines != 0 |->
        ((8'he6 >> cascade_select_lines) & 8'h01) != 0) else $error("sel");
    a_sel_act: assert property (cascade_select_lines != 0 |->
        cascade_active || $past(cascade_active)) else $error("sel idle");
    a_oe_act: assert property (upper_address_oe |->
        cascade_active || $past(cascade_active)) else $error("oe");
    a_upper_idle: assert property (upper_address_outputs != 0 |->
        upper_address_oe || $past(upper_address_oe)) else $error("upper");
    a_int_match: assert property (internal_slave_addressed |->
        $past(cascade_select_lines) == 3'h2) else $error("int");
endmodule

// *** test/slave_model.sv ***
`timescale 1ns/1ns
// slave controller: matches the cascade code against its own identity
module slave_model
#(
    parameter ID = 3'h2
)
(
    input  wire       mclk,
    input  wire [2:0] sel,
    input  wire       act,
    output logic      hit_r
);
    // registered like a real slave, one edge late
    always @(posedge mclk) hit_r <= act && sel == ID;
endmodule

// *** test/tb.sv ***
`timescale 1ns/1ns
module tb;
    logic        mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, hit;
    logic [15:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    wire         wb_ack_o, cascade_active, upper_address_oe, internal_slave_addressed;
    wire [2:0]   cascade_select_lines, upper_address_outputs;
    int          n_mismatch, cmp_count;
    // address, write byte, expected read byte; cascade words set up first
    // rows 1 and 2 keep bit 2 set, bits 4,3,0 clear row 4 gives id 2
    logic [31:0] rows [6] = '{32'hf021ffe6, 32'h00210004, 32'hf0a1ff07,
                              32'h00a10202, 32'hf000ff00, 32'h0021a6a6};
    interrupt_cascade_config i_interrupt_cascade_config
    (
        .mclk                     (mclk),
        .rst                      (rst),
        .wb_cyc_i                 (wb_cyc_i),
        .wb_stb_i                 (wb_stb_i),
        .wb_we_i                  (wb_we_i),
        .wb_adr_i                 (wb_adr_i),
        .wb_sel_i                 (wb_sel_i),
        .wb_dat_i                 (wb_dat_i),
        .wb_dat_o                 (wb_dat_o),
        .wb_ack_o                 (wb_ack_o),
        .cascade_select_lines     (cascade_select_lines),
        .cascade_active           (cascade_active),
        .upper_address_outputs    (upper_address_outputs),
        .upper_address_oe         (upper_address_oe),
        .internal_slave_addressed (internal_slave_addressed)
    );
    slave_model i_slave_model (.mclk, .sel(cascade_select_lines),
                               .act(cascade_active), .hit_r(hit));
    initial
    begin
        mclk = 0;
        forever #10 mclk = ~mclk;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task wb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task final_report;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (1000) @(posedge mclk);
        n_mismatch++;
        final_report;
    end
    initial
    begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 51'h0};
        wb_sel_i = 4'h1;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        wb(0, 16'hf021, 8'h00);
        chk(rd, 32'h04);
        wb(0, 16'hf0a1, 8'h00);
        chk(rd, 32'h02);
        foreach (rows[i])
        begin
            wb(1, rows[i][31:16], rows[i][15:8]);
            wb(0, rows[i][31:16], 8'h00);
            chk(rd, {24'h0, rows[i][7:0]});
        end
        wb(1, 16'hf0c0, 8'h80);
        wb(1, 16'hf0c1, 8'h0e);
        repeat (4) @(negedge mclk);
        chk(cascade_active, 1'b0);
        wb(1, 16'hf0c1, 8'h0a);
        repeat (4) @(negedge mclk);
        chk(cascade_select_lines, 3'h2);
        chk(upper_address_outputs, 3'h2);
        chk({internal_slave_addressed, hit}, 2'b11);
        wb(1, 16'hf0c1, 8'h00);
        wb(1, 16'hf0c1, 8'h0f);
        repeat (4) @(negedge mclk);
        chk({cascade_select_lines, upper_address_outputs, hit}, 7'h7e);
        wb(1, 16'hf0c0, 8'h00);
        repeat (4) @(negedge mclk);
        chk({upper_address_oe, cascade_select_lines}, 4'h7);
        // reset in mid-run while an access is still driving the lines
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({cascade_select_lines, upper_address_outputs, cascade_active}, 7'h00);
        chk({upper_address_oe, internal_slave_addressed, wb_ack_o}, 3'h0);
        wb(0, 16'h0021, 8'h00);
        chk(rd, 32'h04);
        wb(0, 16'hf0c0, 8'h00);
        chk(rd, 32'h00);
        final_report;
    end
endmodule
bind interrupt_cascade_config cascade_checker i_cascade_checker (.*);
